// ===== CRCMS_pkg.sv
// package: register map, field positions and helpers of the crc engine
`default_nettype none
package CRCMS_pkg;
	localparam int          ADDR_W      = 14;
	localparam logic [11:0] IDX_DATA    = 12'hf3f;
	localparam logic [11:0] IDX_ACC     = 12'hf41;
	localparam logic [11:0] IDX_SHIFT   = 12'hf43;
	localparam logic [11:0] IDX_POLY    = 12'hf45;
	localparam logic [11:0] IDX_CON0    = 12'hf47;
	localparam logic [11:0] IDX_CON1    = 12'hf48;
	localparam logic [11:0] IDX_SCUR    = 12'hf49;
	localparam logic [11:0] IDX_SEND    = 12'hf4c;
	localparam logic [11:0] IDX_SCON    = 12'hf4f;
	localparam int          B_EN        = 7;
	localparam int          B_GO        = 6;
	localparam int          B_BUSY      = 5;
	localparam int          B_ZERO_AUGMENT_SELECT      = 4;
	localparam int          B_SHIFT_DIRECTION_SELECT    = 1;
	localparam int          B_FULL      = 0;
	localparam int          B_INV       = 4;
	localparam int          B_SCANNER_INTERRUPT_POLICY      = 3;
	localparam int          DATA_LENGTH_FIELD_LO     = 4;
	localparam int          POLY_LENGTH_FIELD_LO     = 0;
	localparam logic [1:0]  MODE_TRIG   = 2'h3;
	localparam logic [1:0]  MODE_PEEK   = 2'h2;
	localparam logic [1:0]  MODE_BURST  = 2'h1;
	localparam logic [1:0]  MODE_CONC   = 2'h0;
	localparam logic [15:0] RST_ACC     = 16'h0000;
	localparam logic [15:1] RST_POLY    = 15'h0000;
	localparam logic [21:0] RST_SEND    = 22'h3fffff;
	localparam logic        RST_INV     = 1'b1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic {SC_IDLE, SC_FETCH} CRCMS_scan_e;
	// mask of the low len+1 bits
	function automatic logic [15:0] len_mask(input logic [3:0] len);
		logic [16:0] t;
		t = (17'h00001 << ({1'b0, len} + 5'h01)) - 17'h00001;
		return t[15:0];
	endfunction
	function automatic logic is_mapped(input logic [11:0] idx);
		case (idx)
			IDX_DATA, IDX_ACC, IDX_SHIFT, IDX_POLY, IDX_CON0,
			IDX_CON1, IDX_SCUR, IDX_SEND, IDX_SCON: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== CRCMS_step.sv
// one serial step of the crc accumulator
`timescale 1ns/1ns
`default_nettype none
module CRCMS_step (
	// accumulator and setup
	input  wire logic [15:0] acc,
	input  wire logic [15:0] poly,
	input  wire logic [15:0] mask,
	input  wire logic [3:0]  poly_length_field,
	input  wire logic        dbit,
	input  wire logic        augment,
	input  wire logic        right,
	// result
	output logic      [15:0] nxt
);
	logic        fb;
	logic [15:0] sh;
	always_comb
	begin
		// augmented data enters the register, else it folds into feedback
		fb = (right ? acc[0] : acc[poly_length_field]) ^ (~augment & dbit);
		if (right)
			sh = (acc >> 1) | ((augment & dbit) ? (16'h0001 << poly_length_field) : 16'h0000);
		else
			sh = {acc[14:0], augment & dbit};
		nxt = (sh ^ (fb ? poly : 16'h0000)) & mask;
	end
endmodule
`default_nettype wire

// ===== CRCMS_axil.sv
// axi4-lite slave front end for the crc register file
`timescale 1ns/1ns
`default_nettype none
module CRCMS_axil (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// write address and data
	input  wire logic [CRCMS_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	// write response
	output logic      [1:0]                   bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	// read channels
	input  wire logic [CRCMS_pkg::ADDR_W-1:0] araddr,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic      [31:0]                  rdata,
	output logic      [1:0]                   rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	// register side
	output logic                              wr_en,
	output logic      [11:0]                  wr_idx,
	output logic      [31:0]                  wr_data,
	output logic      [3:0]                   wr_strb,
	output logic      [11:0]                  rd_idx,
	input  wire logic [31:0]                  rd_data
);
	import CRCMS_pkg::*;
	typedef struct packed {
		logic        aw_rdy;
		logic        w_rdy;
		logic        ar_rdy;
		logic        have_aw;
		logic        have_w;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rd_pend;
		logic [11:0] raddr;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} CRCMS_bus_s;
	localparam CRCMS_bus_s BUS_RESET = '{aw_rdy: 1'b1, w_rdy: 1'b1,
		ar_rdy: 1'b1, default: '0};
	CRCMS_bus_s st_reg;
	CRCMS_bus_s st_next;
	assign wr_en   = st_reg.have_aw & st_reg.have_w & ~st_reg.bvalid;
	assign wr_idx  = st_reg.waddr;
	assign wr_data = st_reg.wdata;
	assign wr_strb = st_reg.wstrb;
	assign rd_idx  = st_reg.raddr;
	assign awready = st_reg.aw_rdy;
	assign wready  = st_reg.w_rdy;
	assign arready = st_reg.ar_rdy;
	assign bvalid  = st_reg.bvalid;
	assign bresp   = st_reg.bresp;
	assign rvalid  = st_reg.rvalid;
	assign rdata   = st_reg.rdata;
	assign rresp   = st_reg.rresp;
	always_comb
	begin
		st_next = st_reg;
		// ready stays low until the response leaves: one write at a time
		if (awvalid && st_reg.aw_rdy)
		begin
			st_next.aw_rdy  = 1'b0;
			st_next.have_aw = 1'b1;
			st_next.waddr   = awaddr[ADDR_W-1:2];
		end
		if (wvalid && st_reg.w_rdy)
		begin
			st_next.w_rdy   = 1'b0;
			st_next.have_w  = 1'b1;
			st_next.wdata   = wdata;
			st_next.wstrb   = wstrb;
		end
		if (wr_en)
		begin
			st_next.have_aw = 1'b0;
			st_next.have_w  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = is_mapped(st_reg.waddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.bvalid && bready)
		begin
			st_next.bvalid  = 1'b0;
			st_next.aw_rdy  = 1'b1;
			st_next.w_rdy   = 1'b1;
		end
		if (arvalid && st_reg.ar_rdy)
		begin
			st_next.ar_rdy  = 1'b0;
			st_next.rd_pend = 1'b1;
			st_next.raddr   = araddr[ADDR_W-1:2];
		end
		if (st_reg.rd_pend)
		begin
			st_next.rd_pend = 1'b0;
			st_next.rvalid  = 1'b1;
			st_next.rdata   = rd_data;
			st_next.rresp   = is_mapped(st_reg.raddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.rvalid && rready)
		begin
			st_next.rvalid  = 1'b0;
			st_next.ar_rdy  = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_reg <= BUS_RESET;
		else
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

// ===== CRCMS_top.sv
// crc engine with program memory scanner, top level
`timescale 1ns/1ns
`default_nettype none
module CRCMS_top #(
	parameter logic [21:0] SCAN_ADDR_LIMIT = 22'h00ffff
) (
	// clock and reset
	input  wire logic                         SYS_CLK,
	input  wire logic                         RST,
	// axi4-lite write channels
	input  wire logic [CRCMS_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                         S_AXI_AWVALID,
	output logic                              S_AXI_AWREADY,
	input  wire logic [31:0]                  S_AXI_WDATA,
	input  wire logic [3:0]                   S_AXI_WSTRB,
	input  wire logic                         S_AXI_WVALID,
	output logic                              S_AXI_WREADY,
	output logic      [1:0]                   S_AXI_BRESP,
	output logic                              S_AXI_BVALID,
	input  wire logic                         S_AXI_BREADY,
	// axi4-lite read channels
	input  wire logic [CRCMS_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                         S_AXI_ARVALID,
	output logic                              S_AXI_ARREADY,
	output logic      [31:0]                  S_AXI_RDATA,
	output logic      [1:0]                   S_AXI_RRESP,
	output logic                              S_AXI_RVALID,
	input  wire logic                         S_AXI_RREADY,
	// program memory fetch port
	output logic                              MEM_REQ,
	output logic      [21:0]                  MEM_ADDR,
	input  wire logic                         MEM_ACK,
	input  wire logic [15:0]                  MEM_RDATA,
	// scanner trigger and cpu stall
	input  wire logic                         SCAN_TRIGGER,
	output logic                              SCAN_CPU_STALL
);
	import CRCMS_pkg::*;
	typedef struct packed {
		logic [15:0] data;
		logic        full;
		logic [15:0] shreg;
		logic [4:0]  cnt;
		logic [15:0] acc;
		logic [15:1] poly;
		logic        en;
		logic        go;
		logic        zero_augment_select;
		logic        shift_direction_select;
		logic [3:0]  data_length_field;
		logic [3:0]  poly_length_field;
		logic        s_en;
		logic        s_go;
		logic        s_scanner_interrupt_policy;
		logic [1:0]  s_mode;
		logic        s_inv;
		logic        s_err;
		logic        s_trig;
		CRCMS_scan_e s_state;
		logic [21:0] s_cur;
		logic [21:0] s_end;
		logic        mem_req;
		logic [21:0] mem_addr;
		logic        stall;
	} CRCMS_top_s;
	localparam CRCMS_top_s ST_RESET = '{acc: RST_ACC, poly: RST_POLY,
		s_end: RST_SEND, s_inv: RST_INV, s_state: SC_IDLE, default: '0};

	CRCMS_top_s  st_reg;
	CRCMS_top_s  st_next;
	logic        wr_en;
	logic [11:0] wr_idx;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [11:0] rd_idx;
	logic [31:0] rd_word;
	logic [15:0] step_acc;
	logic [15:0] dmask;
	logic [15:0] pmask;
	logic        dbit;
	logic        crc_busy;
	logic        crc_rdy;
	logic        scan_busy;
	logic        scan_start;

	CRCMS_axil u_bus (
		.clk     (SYS_CLK),
		.rst     (RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.rd_idx  (rd_idx),
		.rd_data (rd_word)
	);

	CRCMS_step u_step (
		.acc     (st_reg.acc),
		.poly    ({st_reg.poly, 1'b1}),
		.mask    (pmask),
		.poly_length_field    (st_reg.poly_length_field),
		.dbit    (dbit),
		.augment (st_reg.zero_augment_select),
		.right   (st_reg.shift_direction_select),
		.nxt     (step_acc)
	);

	assign dmask     = len_mask(st_reg.data_length_field);
	assign pmask     = len_mask(st_reg.poly_length_field);
	assign dbit      = st_reg.shift_direction_select ? st_reg.shreg[0] : st_reg.shreg[st_reg.data_length_field];
	assign crc_busy  = st_reg.full | (st_reg.cnt != 5'h00);
	assign crc_rdy   = st_reg.en & st_reg.go & ~st_reg.full;
	assign scan_busy = st_reg.s_state != SC_IDLE;
	assign scan_start = st_reg.s_en && st_reg.s_go && !scan_busy &&
		!st_reg.s_inv && crc_rdy && (st_reg.s_cur <= st_reg.s_end) &&
		(st_reg.s_mode != MODE_TRIG || st_reg.s_trig);

	always_comb
	begin
		rd_word = 32'h00000000;
		case (rd_idx)
			IDX_DATA:  rd_word[15:0] = st_reg.data;
			IDX_ACC:   rd_word[15:0] = st_reg.acc;
			IDX_SHIFT: rd_word[15:0] = st_reg.shreg;
			IDX_POLY:  rd_word[15:0] = {st_reg.poly, 1'b1};
			IDX_CON0:
			begin
				rd_word[B_EN]     = st_reg.en;
				rd_word[B_GO]     = st_reg.go;
				rd_word[B_BUSY]   = crc_busy;
				rd_word[B_ZERO_AUGMENT_SELECT]   = st_reg.zero_augment_select;
				rd_word[B_SHIFT_DIRECTION_SELECT] = st_reg.shift_direction_select;
				rd_word[B_FULL]   = st_reg.full;
			end
			IDX_CON1:  rd_word[7:0] = {st_reg.data_length_field, st_reg.poly_length_field};
			IDX_SCUR:  rd_word[21:0] = st_reg.s_cur;
			IDX_SEND:  rd_word[21:0] = st_reg.s_end;
			IDX_SCON:
			begin
				rd_word[B_EN]   = st_reg.s_en;
				rd_word[B_GO]   = st_reg.s_go;
				rd_word[B_BUSY] = scan_busy;
				rd_word[B_INV]  = st_reg.s_inv;
				rd_word[B_SCANNER_INTERRUPT_POLICY] = st_reg.s_scanner_interrupt_policy;
				rd_word[1:0]    = st_reg.s_mode;
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	always_comb
	begin
		st_next = st_reg;
		// serial shifter: one data bit per clock while started
		if (st_reg.en && st_reg.go && st_reg.cnt != 5'h00)
		begin
			st_next.acc = step_acc;
			if (st_reg.shift_direction_select)
				st_next.shreg = st_reg.shreg >> 1;
			else
				st_next.shreg = (st_reg.shreg << 1) & dmask;
			st_next.cnt = st_reg.cnt - 5'h01;
		end
		else if (st_reg.en && st_reg.go && st_reg.full)
		begin
			st_next.shreg = st_reg.data & dmask;
			st_next.cnt   = {1'b0, st_reg.data_length_field} + 5'h01;
			st_next.full  = 1'b0;
		end
		if (wr_en)
		begin
			case (wr_idx)
				IDX_DATA:
				begin
					if (wr_strb[0])
						st_next.data[7:0] = wr_data[7:0];
					if (wr_strb[1])
						st_next.data[15:8] = wr_data[15:8];
					// a new word beats the transfer of the old one
					if (st_reg.en && (wr_strb[0] || wr_strb[1]))
						st_next.full = 1'b1;
				end
				IDX_ACC:
				begin
					if (wr_strb[0])
						st_next.acc[7:0] = wr_data[7:0];
					if (wr_strb[1])
						st_next.acc[15:8] = wr_data[15:8];
				end
				IDX_POLY:
				begin
					if (wr_strb[0])
						st_next.poly[7:1] = wr_data[7:1];
					if (wr_strb[1])
						st_next.poly[15:8] = wr_data[15:8];
				end
				IDX_CON0:
				begin
					if (wr_strb[0])
					begin
						st_next.en     = wr_data[B_EN];
						st_next.go     = wr_data[B_GO];
						st_next.zero_augment_select   = wr_data[B_ZERO_AUGMENT_SELECT];
						st_next.shift_direction_select = wr_data[B_SHIFT_DIRECTION_SELECT];
					end
				end
				IDX_CON1:
				begin
					if (wr_strb[0])
					begin
						st_next.data_length_field = wr_data[DATA_LENGTH_FIELD_LO+3:DATA_LENGTH_FIELD_LO];
						st_next.poly_length_field = wr_data[POLY_LENGTH_FIELD_LO+3:POLY_LENGTH_FIELD_LO];
					end
				end
				IDX_SCUR:
				begin
					// address writes ignored while a scan runs
					if (!st_reg.s_go && wr_strb[0])
						st_next.s_cur[7:0] = wr_data[7:0];
					if (!st_reg.s_go && wr_strb[1])
						st_next.s_cur[15:8] = wr_data[15:8];
					if (!st_reg.s_go && wr_strb[2])
						st_next.s_cur[21:16] = wr_data[21:16];
				end
				IDX_SEND:
				begin
					if (!st_reg.s_go && wr_strb[0])
						st_next.s_end[7:0] = wr_data[7:0];
					if (!st_reg.s_go && wr_strb[1])
						st_next.s_end[15:8] = wr_data[15:8];
					if (!st_reg.s_go && wr_strb[2])
						st_next.s_end[21:16] = wr_data[21:16];
				end
				IDX_SCON:
				begin
					if (wr_strb[0])
					begin
						st_next.s_en   = wr_data[B_EN];
						st_next.s_go   = wr_data[B_GO];
						st_next.s_scanner_interrupt_policy = wr_data[B_SCANNER_INTERRUPT_POLICY];
						st_next.s_mode = wr_data[1:0];
						// go without a running crc is a setup fault
						if (wr_data[B_GO])
							st_next.s_err = !(st_reg.en && st_reg.go);
					end
				end
				default: ;
			endcase
		end
		// scanner sequencing
		if (scan_start)
		begin
			st_next.mem_req  = 1'b1;
			st_next.mem_addr = st_reg.s_cur;
			st_next.s_state  = SC_FETCH;
			if (st_reg.s_mode == MODE_TRIG)
				st_next.s_trig = 1'b0;
		end
		if (SCAN_TRIGGER)
			st_next.s_trig = 1'b1;
		case (st_reg.s_state)
			SC_FETCH:
			begin
				if (MEM_ACK)
				begin
					st_next.mem_req = 1'b0;
					st_next.s_state = SC_IDLE;
					st_next.data    = MEM_RDATA;
					st_next.full    = 1'b1;
					st_next.s_cur   = st_reg.s_cur + 22'h000001;
				end
			end
			SC_IDLE: ;
			default: st_next.s_state = SC_IDLE;
		endcase
		// hardware clear beats a software set of go
		if (st_reg.s_go && !scan_busy && st_reg.s_cur > st_reg.s_end)
			st_next.s_go = 1'b0;
		st_next.s_inv = (st_reg.s_cur > SCAN_ADDR_LIMIT) || st_reg.s_err;
		// burst mode holds the cpu while the scan runs
		st_next.stall = st_reg.s_en && st_reg.s_go && st_reg.s_mode == MODE_BURST;
		if (!st_next.en)
		begin
			st_next.full  = 1'b0;
			st_next.cnt   = 5'h00;
			st_next.shreg = 16'h0000;
		end
		if (!st_next.s_en)
		begin
			st_next.s_go    = 1'b0;
			st_next.s_state = SC_IDLE;
			st_next.mem_req = 1'b0;
			st_next.s_trig  = 1'b0;
			st_next.s_err   = 1'b0;
			st_next.stall   = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			st_reg <= ST_RESET;
		else
			st_reg <= st_next;
	end

	assign MEM_REQ        = st_reg.mem_req;
	assign MEM_ADDR       = st_reg.mem_addr;
	assign SCAN_CPU_STALL = st_reg.stall;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	sequence fetch_taken;
		st_reg.mem_req && MEM_ACK && st_reg.s_en && !wr_en;
	endsequence
	sequence word_delivered;
		!st_reg.mem_req && st_reg.full && st_reg.s_state == SC_IDLE;
	endsequence

	crc_held_a: assert property (!st_reg.en |-> st_reg.cnt == 5'h00 && !st_reg.full)
		else $error("crc state active while disabled");
	shift_count_a: assert property (st_reg.en && st_reg.go && st_reg.cnt != 5'h00 && !wr_en
		|=> st_reg.cnt == $past(st_reg.cnt) - 5'h01)
		else $error("shifter did not advance one bit");
	shift_hold_a: assert property (st_reg.en && !st_reg.go && !wr_en
		|=> $stable(st_reg.cnt) && $stable(st_reg.shreg))
		else $error("shifter moved while stopped");
	load_word_a: assert property (st_reg.en && st_reg.go && st_reg.full &&
		st_reg.cnt == 5'h00 && !wr_en && !(scan_busy && MEM_ACK)
		|=> !st_reg.full && st_reg.cnt == {1'b0, $past(st_reg.data_length_field)} + 5'h01)
		else $error("data word not moved into shifter");
	busy_idle_a: assert property (st_reg.en && st_reg.go && !wr_en && !scan_busy
		&& !crc_busy |=> !crc_busy)
		else $error("busy rose with no data");
	const_term_a: assert property (rd_idx == IDX_POLY |-> rd_word[0])
		else $error("constant term read as zero");
	scan_reset_a: assert property (!st_reg.s_en |-> !st_reg.s_go &&
		!st_reg.mem_req && !st_reg.stall && st_reg.s_state == SC_IDLE)
		else $error("scanner not reset when disabled");
	scan_off_a: assert property (!st_next.s_en |=> !st_reg.s_go && !st_reg.mem_req)
		else $error("scanner active after disable");
	fetch_issue_a: assert property (scan_start && !wr_en |=> st_reg.mem_req &&
		st_reg.mem_addr == $past(st_reg.s_cur) && scan_busy)
		else $error("fetch not issued at current address");
	fetch_done_a: assert property (fetch_taken |=> word_delivered ##0
		st_reg.s_cur == $past(st_reg.s_cur) + 22'h000001)
		else $error("fetched word not handed to crc");
	trig_wait_a: assert property (st_reg.s_mode == MODE_TRIG && !st_reg.s_trig
		&& !scan_busy |=> !scan_busy)
		else $error("triggered mode fetched without trigger");
	go_clear_a: assert property (st_reg.s_go && !scan_busy &&
		st_reg.s_cur > st_reg.s_end |=> !st_reg.s_go)
		else $error("go not cleared past end address");
	inv_flag_a: assert property (st_reg.s_cur > SCAN_ADDR_LIMIT && !wr_en
		|=> st_reg.s_inv)
		else $error("invalid address not flagged");
endmodule
`default_nettype wire

// ===== CRCMS_mem_model.sv
// program memory model answering scanner fetches after a delay
`timescale 1ns/1ns
`default_nettype none
module CRCMS_mem_model (
	// clock and fetch port
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic [21:0] addr,
	output logic             ack,
	output logic      [15:0] rdata
);
	logic [1:0] wait_reg = 2'h0;
	logic       hit;
	initial ack = 1'b0;
	initial rdata = 16'h0000;
	assign hit = req && !ack && wait_reg == addr[1:0];
	// delay of 0..3 cycles set by the address: prompt and slow answers
	// outside an answer the data lines toggle, never a stale word
	always @(posedge clk)
	begin
		ack <= hit;
		rdata <= hit ? addr[15:0] ^ 16'h5a3c : ~rdata;
		wait_reg <= (req && !ack && !hit) ? wait_reg + 2'h1 : 2'h0;
	end
endmodule
`default_nettype wire

// ===== tb_crc_engine_with_memory_scanner.sv
// self-checking bench for the crc engine and memory scanner
`timescale 1ns/1ns
`default_nettype none
module tb_crc_engine_with_memory_scanner;
	import CRCMS_pkg::*;
	logic        clk, rst, awv, wv, br, arv, rr, trig;
	logic        awr, wrdy, bv, arr, rv, req, ack;
	logic [13:0] awa, ara;
	logic [31:0] wd, rdat, d;
	logic [3:0]  ws;
	logic [1:0]  bresp, rresp;
	logic [21:0] maddr;
	logic        stall;
	logic [15:0] mdat, e;
	int          n_mismatch, tests_run;
	always #10 clk = ~clk;
	always @(posedge clk) trig <= ~trig;
	CRCMS_top CRCMS_top_inst (.SYS_CLK(clk), .RST(rst),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .MEM_REQ(req),
		.MEM_ADDR(maddr), .MEM_ACK(ack), .MEM_RDATA(mdat),
		.SCAN_TRIGGER(trig), .SCAN_CPU_STALL(stall));
	CRCMS_mem_model CRCMS_mem_model_inst (.clk(clk), .req(req),
		.addr(maddr), .ack(ack), .rdata(mdat));
	task print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, g, x);
		end
	endtask
	// a wait that ran out of its bound ends the run
	task fail;
		chk(32'h0, 32'h1);
		print_verdict();
	endtask
	task automatic wr(input logic [11:0] i, input logic [31:0] v,
		input logic [3:0] s = 4'h3, input logic [1:0] er = 2'h0);
		int j;
		@(posedge clk);
		awa <= {i, 2'b00};
		wd <= v;
		ws <= s;
		{awv, wv, br} <= 3'b111;
		j = 0;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			j++;
		end
		while (!bv && j < 50);
		br <= 1'b0;
		if (!bv)
			fail();
		else
			chk(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [11:0] i, output logic [31:0] v,
		input logic [1:0] er = 2'h0);
		int j;
		@(posedge clk);
		ara <= {i, 2'b00};
		{arv, rr} <= 2'b11;
		j = 0;
		do
		begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
			j++;
		end
		while (!rv && j < 50);
		rr <= 1'b0;
		v = rdat;
		if (!rv)
			fail();
		else
			chk(32'(rresp), 32'(er));
	endtask
	task automatic rc(input logic [11:0] i, input logic [31:0] x);
		rd(i, d);
		chk(d, x);
	endtask
	// polls until the masked bits read zero
	task automatic pz(input logic [11:0] i, input logic [31:0] m);
		int j;
		j = 0;
		do
		begin
			rd(i, d);
			j++;
		end
		while ((d & m) != 0 && j < 100);
		if ((d & m) != 0)
			fail();
	endtask
	function automatic logic [15:0] crc_ref(logic [15:0] a, logic [15:0] p,
		logic [15:0] v, logic [3:0] dl, logic [3:0] pl, logic ag, logic rt);
		logic b;
		logic fb;
		for (int i = 0; i <= dl; i++)
		begin
			b = rt ? v[i] : v[dl - i];
			fb = (rt ? a[0] : a[pl]) ^ (b & !ag);
			a = rt ? (a >> 1) | ({15'h0, b & ag} << pl)
				: (a << 1) | {15'h0, b & ag};
			a = (a ^ (fb ? (p | 16'h1) : 16'h0)) & (16'hffff >> (4'hf - pl));
		end
		return a;
	endfunction
	task t_regs;
		rc(IDX_ACC, 32'h0);
		rc(IDX_POLY, 32'h1);
		rc(IDX_SHIFT, 32'h0);
		rc(IDX_SCON, 32'h0);
		rd(12'h001, d, RESP_SLVERR);
		chk(d, 32'h0);
		wr(12'h001, 32'h5, 4'h1, RESP_SLVERR);
		wr(IDX_ACC, 32'h1234, 4'h1);
		wr(IDX_ACC, 32'hab00, 4'h2);
		rc(IDX_ACC, 32'hab34);
		wr(IDX_SHIFT, 32'hffff);
		rc(IDX_SHIFT, 32'h0);
		wr(IDX_POLY, 32'h1020);
		rc(IDX_POLY, 32'h1021);
		wr(IDX_CON1, 32'h7f);
		rc(IDX_CON1, 32'h7f);
		$display("test registers done");
	endtask
	task automatic t_crc;
		logic [7:0] c0;
		for (int c = 0; c < 4; c++)
		begin
			c0 = {3'b100, c[1], 2'b00, c[0], 1'b0};
			wr(IDX_ACC, 32'hffff);
			wr(IDX_CON0, {24'h0, c0});
			wr(IDX_DATA, 32'hc5 + c);
			rc(IDX_CON0, {24'h0, c0 | 8'h21});
			wr(IDX_CON0, {24'h0, c0 | 8'h40});
			pz(IDX_CON0, 32'h21);
			e = crc_ref(16'hffff, 16'h1021, 16'hc5 + 16'(c), 4'h7, 4'hf,
				c[1], c[0]);
			rc(IDX_ACC, {16'h0, e});
		end
		wr(IDX_CON0, 32'h0);
		wr(IDX_DATA, 32'h1);
		rc(IDX_CON0, 32'h0);
		$display("test crc stream done");
	endtask
	task automatic t_scan;
		wr(IDX_CON1, 32'hf7);
		wr(IDX_POLY, 32'h7);
		for (int m = 0; m < 4; m++)
		begin
			wr(IDX_ACC, 32'h0);
			wr(IDX_CON0, 32'hc0);
			wr(IDX_SCUR, 32'h10, 4'h7);
			wr(IDX_SEND, 32'h12, 4'h7);
			wr(IDX_SCON, 32'hc0 | m, 4'h1);
			// stall follows go one edge later; look between edges
			@(negedge clk);
			chk(32'(stall), 32'(m == 1));
			pz(IDX_SCON, 32'h60);
			rc(IDX_SCUR, 32'h13);
			chk(32'(stall), 32'h0);
			pz(IDX_CON0, 32'h21);
			e = 16'h0;
			for (int a = 16; a < 19; a++)
				e = crc_ref(e, 16'h7, 16'(a) ^ 16'h5a3c, 4'hf, 4'h7, 1'b0, 1'b0);
			rc(IDX_ACC, {16'h0, e});
			wr(IDX_SCON, m, 4'h1);
			rc(IDX_SCON, m);
		end
		wr(IDX_SCUR, 32'h10000, 4'h7);
		rc(IDX_SCON, 32'h13);
		// go with the crc stopped is a setup fault
		wr(IDX_SCUR, 32'h0, 4'h7);
		wr(IDX_CON0, 32'h0);
		wr(IDX_SCON, 32'hc8, 4'h1);
		rc(IDX_SCON, 32'hd8);
		wr(IDX_SCON, 32'h0, 4'h1);
		rc(IDX_SCON, 32'h0);
		$display("test scanner done");
	endtask
	initial
	begin
		{clk, rst, trig} = 3'b010;
		{awv, wv, br, arv, rr} = 5'h00;
		{awa, ara, ws, wd} = '0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_crc();
		t_scan();
		print_verdict();
	end
endmodule
`default_nettype wire
